// ### rtl/imu_pwr_pkg.sv
// constants, field layout and state types of the power-mode control block
// assumes a single 200 MHz system clock feeding every user of this package
package imu_pwr_pkg;

    // register map
    localparam logic [7:0] PWR_CTRL_ADDR  = 8'h6B;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h00;

    // field positions inside power_control_primary
    localparam int RESTART_BIT = 7;
    localparam int SLEEP_BIT   = 6;
    localparam int CYCLE_BIT   = 5;
    localparam int GSTBY_BIT   = 4;
    localparam int TDIS_BIT    = 3;
    localparam int TSRC_LSB    = 0;
    localparam int TSRC_W      = 3;

    // field positions inside axis_standby_bits
    localparam int ACC_STBY_LSB = 3;
    localparam int GYR_STBY_LSB = 0;

    // timing_source_select codes
    typedef enum logic [TSRC_W-1:0] {
        CLK_OSC_A = 3'h0,
        CLK_AUTO1 = 3'h1,
        CLK_AUTO2 = 3'h2,
        CLK_AUTO3 = 3'h3,
        CLK_AUTO4 = 3'h4,
        CLK_AUTO5 = 3'h5,
        CLK_OSC_B = 3'h6,
        CLK_STOP  = 3'h7
    } clk_code_t;

    // timing
    localparam int CLK_PERIOD_NS   = 5;
    localparam int RESTART_TIME_NS = 100;
    localparam int RESTART_CYCLES  = (RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESTART_CNT_W   = 5;
    localparam int BASE_PERIOD_NS  = 1000000;
    localparam int BASE_CYCLES_DFLT = BASE_PERIOD_NS / CLK_PERIOD_NS;

    // restart sequencer states
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_RESTART = 2'b01
    } seq_state_t;

endpackage

// ### rtl/duty_if.sv
// carrier between the power-mode control and its wake timer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface duty_if;
    logic       run;     // cycling is allowed to run
    logic [7:0] divider; // sample-rate divider setting
    logic       wake;    // one-cycle wake event

    modport ctl (output run, output divider, input wake);
    modport tmr (input run, input divider, output wake);
endinterface
`default_nettype wire

// ### rtl/duty_wake_timer.sv
// wake timer for the duty-cycled accelerometer mode
// assumes run and divider come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module duty_wake_timer
    import imu_pwr_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_CYCLES_DFLT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control side
    duty_if.tmr      dif
);
    localparam int PRE_W = $clog2(BASE_CYCLES);

    logic [PRE_W-1:0] pre_q;
    logic [7:0]       div_q;
    logic             wake_q;
    wire              pre_end;
    wire              div_end;

    // one base period elapsed, then divider+1 periods make one interval
    assign pre_end  = (pre_q == PRE_W'(BASE_CYCLES - 1));
    assign div_end  = (div_q == dif.divider);
    assign dif.wake = wake_q;

    // counters restart whenever cycling is not allowed
    always_ff @(posedge clk) begin
        if (!rst_n || !dif.run) begin
            pre_q  <= '0;
            div_q  <= 8'h00;
            wake_q <= 1'b0;
        end else begin
            pre_q  <= pre_end ? '0 : pre_q + 1'b1;
            if (pre_end) begin
                div_q <= div_end ? 8'h00 : div_q + 8'h01;
            end
            wake_q <= pre_end & div_end;
        end
    end

    a_wake_needs_run: assert property (@(posedge clk) disable iff (!rst_n)
        wake_q |-> $past(dif.run)) else $error("wake without run");

endmodule // duty_wake_timer
`default_nettype wire

// ### rtl/imu_power_mode_control.sv
// power-mode control: restart, sleep, duty cycling, standby and timing source
// assumes a register port from the serial host logic on SYS_CLK, PLL_READY
// from an unrelated source, axis standby and divider settings on SYS_CLK
`timescale 1ns/1ps
`default_nettype none
// How it works
// - A one written to the restart bit returns the register fields to defaults.
// - The restart bit reads one only while the restart runs and then clears itself.
// - The sleep bit puts the device in its sleep state.
// - With cycling on, no sleep or standby and a clock code other than 7, the device sleeps and wakes for one sample.
// - The wake interval is divider plus one base periods.
// - With all accelerometer axes off, wakes still happen but take no sample.
// - Cycling acts only while both sleep and standby are zero.
// - Gyro standby keeps drive and PLL on and turns the sense paths off.
// - The temperature-disable bit switches the temperature sensor off.
// - Codes 0 and 6 pick the oscillator; codes 1 to 5 pick the PLL when ready.
// - Code 7 stops the clock and holds the timing generator in reset.
// - The timing-source field is zero after reset.
// - Each axis standby bit turns its axis off, and a zero keeps it on.
module imu_power_mode_control
    import imu_pwr_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_CYCLES_DFLT
) (
    // clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       RESET_N,
    // register port
    input  wire logic       REG_WR_EN,
    input  wire logic       REG_RD_EN,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output var  logic [7:0] REG_RDATA,
    output var  logic       REG_RD_VALID,
    // device status and settings
    input  wire logic       PLL_READY,
    input  wire logic [5:0] AXIS_STANDBY,
    input  wire logic [7:0] SAMPLE_RATE_DIV,
    // restart
    output var  logic       SOFT_RESET_OUT,
    // power states
    output var  logic       SLEEP_ACTIVE,
    output var  logic       WAKE_PULSE,
    output var  logic       ACCEL_SAMPLE_STROBE,
    output var  logic [2:0] ACCEL_AXIS_EN,
    output var  logic [2:0] GYRO_AXIS_EN,
    output var  logic       GYRO_DRIVE_EN,
    output var  logic       GYRO_SENSE_EN,
    output var  logic       TEMP_SENSOR_EN,
    // timing source
    output var  logic       CLK_USE_OSC,
    output var  logic       CLK_USE_PLL,
    output var  logic       CLK_STOPPED,
    output var  logic       TIMING_GEN_RST
);
    localparam int RST_SPAN = RESTART_CYCLES;

    seq_state_t               state_q;
    seq_state_t               state_d;
    logic [RESTART_CNT_W-1:0] cnt_q;
    logic [6:0]               fields_q;
    logic [6:0]               fields_d;
    logic [2:0]               pll_sync_q;
    logic                     pll_ok_q;

    duty_if dif ();

    // register decode
    wire        hit           = (REG_ADDR == PWR_CTRL_ADDR);
    wire        restart_busy  = (state_q == ST_RESTART);
    wire        wr_hit        = REG_WR_EN & hit & ~restart_busy;
    wire        start_restart = wr_hit & REG_WDATA[RESTART_BIT];
    wire        cnt_end       = (cnt_q == RESTART_CNT_W'(RESTART_CYCLES - 1));
    wire [7:0]  rd_word       = {restart_busy, fields_q};

    // field decode
    wire        sleep      = fields_q[SLEEP_BIT];
    wire        gstby      = fields_q[GSTBY_BIT];
    wire        tdis       = fields_q[TDIS_BIT];
    wire [2:0]  clk_code   = fields_q[TSRC_LSB +: TSRC_W];
    wire        cycle_run  = fields_q[CYCLE_BIT] & ~sleep & ~gstby;
    wire        clk_stop   = (clk_code == CLK_STOP);
    wire        clk_auto   = ~clk_stop & (clk_code != CLK_OSC_A) & (clk_code != CLK_OSC_B);
    wire        use_pll    = clk_auto & pll_ok_q;
    wire        accel_any  = ~&AXIS_STANDBY[ACC_STBY_LSB +: 3];

    // wake timer link; a stopped clock also halts cycling
    assign dif.run     = cycle_run & ~clk_stop;
    assign dif.divider = SAMPLE_RATE_DIV;

    // restart sequencer next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (start_restart) begin
                    state_d = ST_RESTART;
                end
            end
            ST_RESTART: begin
                if (cnt_end) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    // field update: restart forces defaults, otherwise take the write
    assign fields_d = (start_restart | restart_busy) ? PWR_CTRL_RESET[6:0]
                    : wr_hit ? REG_WDATA[6:0] : fields_q;

    // sequencer, counter and register fields
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            state_q  <= ST_RUN;
            cnt_q    <= '0;
            fields_q <= PWR_CTRL_RESET[6:0];
        end else begin
            state_q  <= state_d;
            cnt_q    <= restart_busy ? cnt_q + 1'b1 : '0;
            fields_q <= fields_d;
        end
    end

    // PLL ready crosses in; a change counts when the last two stages agree
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            pll_sync_q <= 3'h0;
            pll_ok_q   <= 1'b0;
        end else begin
            pll_sync_q <= {pll_sync_q[1:0], PLL_READY};
            if (pll_sync_q[1] == pll_sync_q[2]) begin
                pll_ok_q <= pll_sync_q[2];
            end
        end
    end

    // register read answer; unmapped reads give zero
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            REG_RDATA    <= 8'h00;
            REG_RD_VALID <= 1'b0;
        end else begin
            REG_RDATA    <= (REG_RD_EN & hit) ? rd_word : 8'h00;
            REG_RD_VALID <= REG_RD_EN;
        end
    end

    // power-state outputs
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            SOFT_RESET_OUT      <= 1'b0;
            SLEEP_ACTIVE        <= 1'b0;
            WAKE_PULSE          <= 1'b0;
            ACCEL_SAMPLE_STROBE <= 1'b0;
            ACCEL_AXIS_EN       <= 3'h0;
            GYRO_AXIS_EN        <= 3'h0;
            GYRO_DRIVE_EN       <= 1'b0;
            GYRO_SENSE_EN       <= 1'b0;
            TEMP_SENSOR_EN      <= 1'b0;
        end else begin
            SOFT_RESET_OUT      <= (state_d == ST_RESTART);
            SLEEP_ACTIVE        <= sleep | (cycle_run & ~dif.wake);
            WAKE_PULSE          <= dif.wake & cycle_run;
            ACCEL_SAMPLE_STROBE <= dif.wake & cycle_run & accel_any;
            ACCEL_AXIS_EN       <= ~AXIS_STANDBY[ACC_STBY_LSB +: 3];
            GYRO_AXIS_EN        <= ~AXIS_STANDBY[GYR_STBY_LSB +: 3];
            GYRO_DRIVE_EN       <= ~sleep & ~cycle_run;
            GYRO_SENSE_EN       <= ~sleep & ~cycle_run & ~gstby;
            TEMP_SENSOR_EN      <= ~sleep & ~tdis;
        end
    end

    // timing-source outputs
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            CLK_USE_OSC    <= 1'b1;
            CLK_USE_PLL    <= 1'b0;
            CLK_STOPPED    <= 1'b0;
            TIMING_GEN_RST <= 1'b0;
        end else begin
            CLK_USE_OSC    <= ~clk_stop & ~use_pll;
            CLK_USE_PLL    <= use_pll;
            CLK_STOPPED    <= clk_stop;
            TIMING_GEN_RST <= clk_stop;
        end
    end

    duty_wake_timer #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_timer (
        .clk   (SYS_CLK),
        .rst_n (RESET_N),
        .dif   (dif)
    );

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_restart_run;
        SOFT_RESET_OUT ##[RST_SPAN:RST_SPAN] !SOFT_RESET_OUT;
    endsequence

    a_restart_length: assert property (start_restart |=> s_restart_run)
        else $error("restart pulse length wrong");
    a_restart_defaults: assert property ($fell(SOFT_RESET_OUT) |->
        fields_q == PWR_CTRL_RESET[6:0]) else $error("fields not default after restart");
    a_restart_selfclear: assert property (REG_RD_VALID && $past(REG_RD_EN && hit &&
        !restart_busy) |-> !REG_RDATA[RESTART_BIT]) else $error("restart bit reads one");
    a_sleep_state: assert property ($past(sleep) |-> SLEEP_ACTIVE)
        else $error("sleep bit without sleep state");
    a_cycle_gated: assert property (WAKE_PULSE |-> $past(cycle_run) &&
        !$past(sleep) && !$past(gstby)) else $error("wake while sleep or standby");
    a_no_axis_sample: assert property (WAKE_PULSE && $past(!accel_any) |->
        !ACCEL_SAMPLE_STROBE) else $error("sample with all axes off");
    a_gyro_standby: assert property ($past(gstby && !sleep) |->
        GYRO_DRIVE_EN && !GYRO_SENSE_EN) else $error("gyro standby wrong");
    a_temp_off: assert property ($past(tdis) |-> !TEMP_SENSOR_EN)
        else $error("temperature sensor not off");
    a_clk_auto: assert property ($past(clk_auto && pll_ok_q) |->
        CLK_USE_PLL && !CLK_USE_OSC) else $error("auto code did not pick PLL");
    a_clk_stop: assert property ($past(clk_stop) |-> CLK_STOPPED && TIMING_GEN_RST &&
        !CLK_USE_OSC && !CLK_USE_PLL) else $error("stop code not honoured");
    a_clk_reset: assert property ($past(!RESET_N) |-> clk_code == CLK_OSC_A)
        else $error("timing source not zero after reset");
    a_axis_standby: assert property ($past(RESET_N) |->
        ACCEL_AXIS_EN == ~$past(AXIS_STANDBY[5:3]) &&
        GYRO_AXIS_EN == ~$past(AXIS_STANDBY[2:0])) else $error("axis enable mismatch");
    a_readback: assert property (wr_hit && !REG_WDATA[RESTART_BIT] ##1
        REG_RD_EN && hit |=> REG_RDATA[6:0] == $past(REG_WDATA[6:0], 2))
        else $error("readback wrong");

endmodule // imu_power_mode_control
`default_nettype wire

// ### verif/imu_power_mode_control_test.sv
// self-checking bench for the power-mode control block and its wake timer
// assumes imu_pwr_pkg, duty_if, duty_wake_timer and the top are compiled first
`timescale 1ns/1ps
`default_nettype none
module imu_power_mode_control_test;
    import imu_pwr_pkg::*;
    localparam int BASE = 8; // short base period keeps wake spacing small

    // bench-side signals
    logic       sys_clk, reset_n, wr_en, rd_en, pll_ready;
    logic [7:0] addr, wdata, rdata, div, q, r;
    logic [5:0] axis_sb;
    logic       rd_valid, soft_rst, sleep_act, wake, strobe;
    logic       drv_en, sense_en, temp_en, use_osc, use_pll, stopped, tg_rst;
    logic [2:0] acc_en, gyr_en, e;
    int         error_cnt, checks_done, seed_val, gap;

    // timing-source outputs packed for one compare
    wire [7:0]  clk_word = {4'h0, use_osc, use_pll, stopped, tg_rst};

    imu_power_mode_control #(.BASE_CYCLES(BASE)) dut (
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RD_VALID(rd_valid),
        .PLL_READY(pll_ready), .AXIS_STANDBY(axis_sb), .SAMPLE_RATE_DIV(div),
        .SOFT_RESET_OUT(soft_rst), .SLEEP_ACTIVE(sleep_act), .WAKE_PULSE(wake),
        .ACCEL_SAMPLE_STROBE(strobe), .ACCEL_AXIS_EN(acc_en), .GYRO_AXIS_EN(gyr_en),
        .GYRO_DRIVE_EN(drv_en), .GYRO_SENSE_EN(sense_en), .TEMP_SENSOR_EN(temp_en),
        .CLK_USE_OSC(use_osc), .CLK_USE_PLL(use_pll), .CLK_STOPPED(stopped),
        .TIMING_GEN_RST(tg_rst));

    // free-running 200 MHz clock
    always #(CLK_PERIOD_NS / 2.0) sys_clk = ~sys_clk;

    // comparisons, one per kind of result
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // expected timing-source outputs {osc, pll, stopped}
    function automatic logic [2:0] clk_exp(input logic [2:0] code, input logic pll);
        logic auto_sel;
        auto_sel = (code >= 3'h1) && (code <= 3'h5);
        return {(code == 3'h0) || (code == 3'h6) || (auto_sel && !pll), auto_sel && pll,
                code == 3'h7};
    endfunction

    // register port cycles: request raised after one edge, taken at the next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        cmp_bit(rd_valid, 1'b1, "read valid");
        d = rdata;
    endtask
    // write, then read in the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r_out);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        cmp_bit(rd_valid, 1'b1, "read valid");
        r_out = rdata;
    endtask

    // watch the duty-cycle outputs for a few wake periods
    task automatic watch(input logic acc_on, input int want);
        int n, last, seen;
        last = -1;
        seen = 0;
        repeat (2) @(posedge sys_clk);
        for (n = 0; n < 3 * gap + 4; n++) begin
            @(posedge sys_clk);
            #1;
            cmp_bit(strobe, wake && acc_on, "sample strobe");
            if (want == 1) cmp_bit(sleep_act, !wake, "sleep between wakes");
            if (wake === 1'b1) begin
                if (last >= 0) cmp_byte(8'(n - last), 8'(gap), "wake spacing");
                last = n;
                seen++;
            end
        end
        cmp_byte(8'(seen > 0), 8'(want), "wake seen");
    endtask

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog sized well above the expected run length
    initial begin
        #200000;
        error_cnt++;
        $display("unexpected at %0t: run did not finish", $time);
        end_sim();
    end

    // main sequence
    initial begin
        sys_clk = 1'b0; reset_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; pll_ready = 1'b0;
        addr = 8'h00; wdata = 8'h00; div = 8'h00; axis_sb = 6'h00;
        error_cnt = 0;
        checks_done = 0;
        seed_val = $urandom(32'hC5C1BB0B);
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(PWR_CTRL_ADDR, q);
        cmp_byte(q, PWR_CTRL_RESET, "reset value");
        cmp_bit(use_osc, 1'b1, "oscillator after reset");
        rd(8'h75, q);
        cmp_byte(q, 8'h00, "unmapped read");
        $display("test defaults done");

        // every timing-source code with and without PLL ready, random sleep, gyro standby and temperature-disable bits
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            wdata <= 8'h00;
            q = (8'($urandom) & 8'h58) | 8'(i[2:0]);
            pll_ready <= i[3];
            axis_sb   <= 6'($urandom);
            wr_rd(PWR_CTRL_ADDR, q, r);
            cmp_byte(r, q, "write then read");
            wr(8'h6C, ~q); // other address, must leave the register alone
            repeat (6) @(posedge sys_clk);
            #1;
            cmp_bit(sleep_act, q[6], "sleep state");
            cmp_bit(drv_en, !q[6], "gyro drive");
            cmp_bit(sense_en, !q[6] && !q[4], "gyro sense");
            cmp_bit(temp_en, !q[6] && !q[3], "temp sensor");
            e = clk_exp(q[2:0], i[3]);
            cmp_byte(clk_word, {4'h0, e, e[0]}, "clock");
            cmp_byte({2'h0, acc_en, gyr_en}, {2'h0, ~axis_sb}, "axis enables");
            rd(PWR_CTRL_ADDR, r);
            cmp_byte(r, q, "readback");
        end
        $display("test fields done");

        // restart wipes the fields, refuses writes, then clears itself
        wr(PWR_CTRL_ADDR, 8'h5D);
        wr(PWR_CTRL_ADDR, 8'hA1);
        rd(PWR_CTRL_ADDR, q);
        cmp_byte(q, 8'h80, "restart in progress");
        cmp_bit(soft_rst, 1'b1, "restart output");
        wr(PWR_CTRL_ADDR, 8'h40);
        #1;
        for (int n = 0; n < 40 && soft_rst === 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        cmp_bit(soft_rst, 1'b0, "restart ends");
        rd(PWR_CTRL_ADDR, q);
        cmp_byte(q, 8'h00, "after restart");
        $display("test restart done");

        // duty cycling: corner divider zero, then a random one
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            div <= (k == 0) ? 8'h00 : 8'($urandom % 4);
            axis_sb <= 6'h00;
            @(posedge sys_clk);
            #1;
            gap = (int'(div) + 1) * BASE;
            wr(PWR_CTRL_ADDR, 8'h21); // host picks the PLL-backed source
            watch(1'b1, 1);
            @(posedge sys_clk);
            axis_sb <= 6'h38;
            watch(1'b0, 1);
            wr(PWR_CTRL_ADDR, 8'h61);
            watch(1'b0, 0);
            wr(PWR_CTRL_ADDR, 8'h31);
            watch(1'b0, 0);
            wr(PWR_CTRL_ADDR, 8'h27); // stopped clock halts cycling
            watch(1'b0, 0);
        end
        $display("test duty cycle done");
        end_sim();
    end
endmodule // imu_power_mode_control_test
`default_nettype wire
